//--- rtl/rx_event_regs.vh
// Register offsets, field positions, reset values and timing counts
// for the receive event flag bank. Definitions only.
`ifndef RX_EVENT_REGS_VH
`define RX_EVENT_REGS_VH

// Register offsets (byte addresses on the plain register port)
`define RX_FLAGS_A_ADDR     8'h09
`define RX_FLAGS_B_ADDR     8'h0a
`define RX_ENABLE_A_ADDR    8'h0b
`define RX_ENABLE_B_ADDR    8'h0c
`define RX_CTRL_ADDR        8'h40

// Flag B field positions
`define FB_IDLE             0
`define FB_TIMER            1
`define FB_ACTIVE           2
`define FB_UNK_VALID        3
`define FB_CSE              4
`define FB_SLIP             5
`define FB_LONG_IDLE        6
`define FB_SPARE            7

// Control register field positions
`define CTRL_CASCADE        0

// Reset values
`define FLAGS_B_RESET       8'h02
`define FLAGS_A_RESET       8'h20
`define ENABLE_RESET        8'h00
`define CTRL_RESET          8'h00

// Symbol codes, five bits each
`define SYM_IDLE            5'h1f
`define SYM_J               5'h18
`define SYM_K               5'h11

// Pair counts for idle detection
`define IDLE_PAIRS          4'h2
`define LONG_IDLE_PAIRS     4'h8

// Cascade start window after ready release
`define CHAIN_WIN_NS        80
`define CLK_NS              20
`define CHAIN_WIN_CYC       (`CHAIN_WIN_NS / `CLK_NS)

`endif

//--- rtl/sync2.v
// Two-flip-flop synchroniser for one level from outside the clock.
// Assumes the input is a level held well over two clock periods.
`timescale 1ns/1ps
module sync2 (
    input  wire clk_in,     // Local clock
    input  wire rst_n_in,   // Async reset, active low
    input  wire d_in,       // Level from outside
    output reg  q_out       // Synchronised level
);
    reg meta;

    // Two stages; first stage read by second only
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta  <= 1'b0;
            q_out <= 1'b0;
        end else begin
            meta  <= d_in;
            q_out <= meta;
        end
    end
endmodule // sync2

//--- rtl/rx_line_state_event_flags.v
// Receive line-state event flags B, enables A and B, flags A holding
// bits and the two interrupt summary bits.
// Assumes symbol pairs and line-state pulses come from logic on clk_in;
// the cascade start pin is asynchronous and synchronised here.
//
// How it works
// - New line state sets flag, keeps others
// - Summary B: any flag B with enable
// - Two idle pairs set idle flag
// - Timer flag set at zero, held until reload
// - Reset makes timer flag one
// - JK pair sets active flag
// - Unknown after active/idle sets bit three
// - Masked management condition sets bit four, cascade off only
// - Late cascade start sets bit four
// - Buffer slip sets sticky bit five
// - Eight idle pairs set long idle
// - Spare bit reads zero, writes ignored
// - Summary A: any flag A with enable
// - Enable A resets to zero
// - Enable A bit n gates flag A n
// - Flag A holds eight companion events
// - Noise counter zero sets noise expiry
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`include "rx_event_regs.vh"
module rx_line_state_event_flags (
    input  wire       clk_in,            // Local clock, 50 MHz
    input  wire       rst_n_in,          // Async reset, active low
    input  wire [7:0] addr_in,           // Register address
    input  wire [7:0] wdata_in,          // Write data
    input  wire       wr_in,             // Write strobe
    input  wire       rd_in,             // Read strobe
    output reg  [7:0] rdata_out,         // Read data, cycle after rd
    input  wire       pair_valid_in,     // Symbol pair present
    input  wire [4:0] sym_hi_in,         // First symbol of pair
    input  wire [4:0] sym_lo_in,         // Second symbol of pair
    input  wire       unknown_in,        // No known line state now
    input  wire       state_cnt_zero_in, // State counter at zero
    input  wire       state_reload_in,   // Nonzero threshold loaded
    input  wire [7:0] conn_mgmt_cond_in, // Management condition bits
    input  wire [7:0] conn_mgmt_cond_mask_in, // Management mask bits
    input  wire       chain_ready_in,    // Cascade ready, local level
    input  wire       chain_start_in,    // Cascade start pin, async
    input  wire       slip_in,           // Elastic buffer over/under
    input  wire [7:0] flags_a_set_in,    // Companion event pulses
    input  wire       noise_cnt_zero_in, // Noise counter at zero
    input  wire       noise_reload_in,   // Noise threshold reloaded
    output reg        rx_cond_a_summary_out, // Summary A to cause reg
    output reg        rx_cond_b_summary_out  // Summary B to cause reg
);
    // ----------------------------------------
    // Registers and state
    // ----------------------------------------
    reg  [7:0] flags_b;
    reg  [7:0] flags_a;
    reg  [7:0] enable_a;
    reg  [7:0] enable_b;
    reg  [7:0] ctrl;
    reg  [3:0] idle_run;
    reg  [1:0] last_known;   // 0 none, 1 active/idle, 2 other
    reg        timer_hold;
    reg        noise_hold;
    reg        ready_d;
    reg  [2:0] win_cnt;
    reg        win_open;
    wire       start_sync;
    reg  [7:0] next_flags_b;
    reg  [7:0] next_flags_a;
    reg  [7:0] set_b;
    reg  [7:0] clr_b;
    reg  [7:0] clr_a;
    wire       idle_pair;
    wire       jk_pair;
    wire       chain_err;
    wire       cascade_on;

    localparam integer WIN_INT = `CHAIN_WIN_CYC;
    localparam [2:0]   WIN_CYC = WIN_INT[2:0];   // Window length in cycles

    // Cascade start pin synchroniser
    sync2 u_start_sync (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .d_in     (chain_start_in),
        .q_out    (start_sync)
    );

    assign idle_pair  = pair_valid_in && sym_hi_in == `SYM_IDLE
                        && sym_lo_in == `SYM_IDLE;
    assign jk_pair    = pair_valid_in && sym_hi_in == `SYM_J
                        && sym_lo_in == `SYM_K;
    assign cascade_on = ctrl[`CTRL_CASCADE];

    // ----------------------------------------
    // Line-state detection
    // ----------------------------------------
    // Idle pair run counter, saturates at eight
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            idle_run <= 4'h0;
        end else if (pair_valid_in) begin
            if (!idle_pair)
                idle_run <= 4'h0;
            else if (idle_run != `LONG_IDLE_PAIRS)
                idle_run <= idle_run + 4'h1;
        end
    end

    // Track most recent known state for unknown qualification
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            last_known <= 2'd0;
        end else if (jk_pair || idle_pair) begin
            last_known <= 2'd1;
        end else if (|flags_a_set_in[4:0]) begin
            last_known <= 2'd2;
        end
    end

    // Timer and noise holds: stay set until a reload is seen
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            timer_hold <= 1'b1;
            noise_hold <= 1'b1;
        end else begin
            if (state_cnt_zero_in)
                timer_hold <= 1'b1;
            else if (state_reload_in)
                timer_hold <= 1'b0;
            if (noise_cnt_zero_in)
                noise_hold <= 1'b1;
            else if (noise_reload_in)
                noise_hold <= 1'b0;
        end
    end

    // ----------------------------------------
    // Cascade start window
    // ----------------------------------------
    // Open a window on ready release; error if start is late
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ready_d  <= 1'b0;
            win_open <= 1'b0;
            win_cnt  <= 3'h0;
        end else begin
            ready_d <= chain_ready_in;
            if (ready_d && !chain_ready_in && cascade_on) begin
                win_open <= 1'b1;
                win_cnt  <= 3'h0;
            end else if (win_open) begin
                if (start_sync || win_cnt == WIN_CYC)
                    win_open <= 1'b0;
                win_cnt <= win_cnt + 3'h1;
            end
        end
    end
    assign chain_err = win_open && !start_sync
                       && win_cnt == WIN_CYC;

    // ----------------------------------------
    // Flag set and clear
    // ----------------------------------------
    // Collect set sources and software clears
    always @* begin
        set_b = 8'h00;
        set_b[`FB_IDLE]      = idle_pair
                               && idle_run + 4'h1 >= `IDLE_PAIRS;
        set_b[`FB_TIMER]     = timer_hold;
        set_b[`FB_ACTIVE]    = jk_pair;
        set_b[`FB_UNK_VALID] = unknown_in
                               && last_known == 2'd1;
        set_b[`FB_CSE]       = cascade_on ? chain_err
                   : |(conn_mgmt_cond_in & conn_mgmt_cond_mask_in);
        set_b[`FB_SLIP]      = slip_in;
        set_b[`FB_LONG_IDLE] = idle_pair
                               && idle_run + 4'h1 >= `LONG_IDLE_PAIRS;
        clr_b = 8'h00;
        clr_a = 8'h00;
        if (wr_in && addr_in == `RX_FLAGS_B_ADDR)
            clr_b = ~wdata_in;
        if (wr_in && addr_in == `RX_FLAGS_A_ADDR)
            clr_a = ~wdata_in;
        // Set wins: clear first, then OR in sets; history kept
        next_flags_b = (flags_b & ~clr_b) | set_b;
        next_flags_b[`FB_SPARE] = 1'b0;
        next_flags_a = (flags_a & ~clr_a) | flags_a_set_in;
        next_flags_a[5] = next_flags_a[5] | noise_hold;
    end

    // Flag registers
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            flags_b <= `FLAGS_B_RESET;
            flags_a <= `FLAGS_A_RESET;
        end else begin
            flags_b <= next_flags_b;
            flags_a <= next_flags_a;
        end
    end

    // ----------------------------------------
    // Enable and control registers
    // ----------------------------------------
    // Plain read/write registers
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            enable_a <= `ENABLE_RESET;
            enable_b <= `ENABLE_RESET;
            ctrl     <= `CTRL_RESET;
        end else if (wr_in) begin
            case (addr_in)
                `RX_ENABLE_A_ADDR: enable_a <= wdata_in;
                `RX_ENABLE_B_ADDR: enable_b <= wdata_in;
                `RX_CTRL_ADDR:     ctrl     <= {7'h00, wdata_in[0]};
                default:           ctrl     <= ctrl;
            endcase
        end
    end

    // ----------------------------------------
    // Read data and summaries
    // ----------------------------------------
    // Read port, data one cycle after strobe; unmapped reads zero
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_out <= 8'h00;
        end else if (rd_in) begin
            case (addr_in)
                `RX_FLAGS_A_ADDR:  rdata_out <= flags_a;
                `RX_FLAGS_B_ADDR:  rdata_out <= flags_b;
                `RX_ENABLE_A_ADDR: rdata_out <= enable_a;
                `RX_ENABLE_B_ADDR: rdata_out <= enable_b;
                `RX_CTRL_ADDR:     rdata_out <= ctrl;
                default:           rdata_out <= 8'h00;
            endcase
        end else begin
            rdata_out <= 8'h00;
        end
    end

    // Masked summaries from current flags
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_cond_a_summary_out <= 1'b0;
            rx_cond_b_summary_out <= 1'b0;
        end else begin
            rx_cond_a_summary_out <= |(flags_a & enable_a);
            rx_cond_b_summary_out <= |(flags_b & enable_b);
        end
    end
endmodule // rx_line_state_event_flags

//--- testbench/rx_flags_monitor.sv
// Checker for the receive event flag bank, sees top ports only.
// Assumes a bind onto rx_line_state_event_flags, one clock domain.
`timescale 1ns/1ps
module rx_flags_monitor (
    input wire       clk_in,                // Clock
    input wire       rst_n_in,              // Reset, active low
    input wire [7:0] addr_in,               // Address
    input wire [7:0] wdata_in,              // Write data
    input wire       wr_in,                 // Write strobe
    input wire       rd_in,                 // Read strobe
    input wire [7:0] rdata_out,             // Read data
    input wire       slip_in,               // Buffer slip
    input wire [7:0] flags_a_set_in,        // Events A
    input wire       rx_cond_a_summary_out, // Summary A
    input wire       rx_cond_b_summary_out  // Summary B
);
    reg [7:0] en_a;
    reg [7:0] en_b;

    default clocking dc @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    // Shadow copies of both enable registers
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            en_a <= 8'h00;
            en_b <= 8'h00;
        end else if (wr_in) begin
            if (addr_in == 8'h0b) en_a <= wdata_in;
            if (addr_in == 8'h0c) en_b <= wdata_in;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    spare_reads_zero_a: assert property (rd_in && addr_in == 8'h0a
        |=> !rdata_out[7]) else $error("spare bit read as one");
    flags_b_sticky_a: assert property ($fell(rx_cond_b_summary_out)
        |-> $past(wr_in, 2) && ($past(addr_in, 2) == 8'h0a
        || $past(addr_in, 2) == 8'h0c)) else $error("summary b fell alone");
    mask_a_off_a: assert property (en_a == 8'h00
        |=> !rx_cond_a_summary_out) else $error("summary a unmasked");
    mask_b_off_a: assert property (en_b == 8'h00
        |=> !rx_cond_b_summary_out) else $error("summary b unmasked");
    event_a_summary_a: assert property ((|(en_a & flags_a_set_in))
        && !wr_in |-> ##2 rx_cond_a_summary_out) else $error("no summary a");
    slip_summary_a: assert property (en_b[5] && slip_in && !wr_in
        |-> ##2 rx_cond_b_summary_out) else $error("no summary b");
    slip_read_a: assert property (rd_in && addr_in == 8'h0a
        && $past(slip_in) |=> rdata_out[5]) else $error("slip flag lost");
    event_a_read_a: assert property (rd_in && addr_in == 8'h09
        |=> (rdata_out & $past(flags_a_set_in, 2))
        == $past(flags_a_set_in, 2)) else $error("flag a lost");

    // Main scenarios reached
    cover property (rx_cond_a_summary_out);
    cover property (rx_cond_b_summary_out);
    cover property (rd_in && addr_in == 8'h0a && $past(slip_in));
endmodule // rx_flags_monitor

//--- testbench/rx_line_state_event_flags_tb_top.sv
// Bench for the receive event flag bank: register call sequences.
// Assumes the design and rx_flags_monitor are compiled before it.
`timescale 1ns/1ps
module rx_line_state_event_flags_tb_top;
    logic       clk_in = 0, rst_n_in = 0, wr_in = 0, rd_in = 0;
    logic       pair_valid_in = 0, unknown_in = 0, state_reload_in = 0;
    logic       chain_ready_in = 0, chain_start_in = 0, slip_in = 0;
    logic       noise_reload_in = 0;
    logic       rx_cond_a_summary_out, rx_cond_b_summary_out;
    logic [4:0] sym_hi_in = 0, sym_lo_in = 0;
    logic [7:0] addr_in = 0, wdata_in = 0, rdata_out, flags_a_set_in = 0;
    logic [7:0] conn_mgmt_cond_in = 0, conn_mgmt_cond_mask_in = 0;
    logic       state_cnt_zero_in = 1'b0;
    logic       noise_cnt_zero_in = 1'b0;
    int         fail_count = 0, check_count = 0, i;

    // Clock, 20 ns period
    initial forever #10 clk_in = ~clk_in;

    rx_line_state_event_flags rx_line_state_event_flags_inst (
        .clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
        .pair_valid_in, .sym_hi_in, .sym_lo_in, .unknown_in,
        .state_cnt_zero_in, .state_reload_in, .conn_mgmt_cond_in,
        .conn_mgmt_cond_mask_in, .chain_ready_in, .chain_start_in,
        .slip_in, .flags_a_set_in, .noise_cnt_zero_in, .noise_reload_in,
        .rx_cond_a_summary_out, .rx_cond_b_summary_out);

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        @(negedge clk_in);
        chk(rdata_out, exp);
    endtask
    task pairs(input int n, input logic [4:0] hi, input logic [4:0] lo);
        @(posedge clk_in);
        pair_valid_in <= 1'b1;
        sym_hi_in <= hi;
        sym_lo_in <= lo;
        repeat (n) @(posedge clk_in);
        pair_valid_in <= 1'b0;
    endtask
    task pulse_a(input logic [7:0] b);
        @(posedge clk_in) flags_a_set_in <= b;
        @(posedge clk_in) flags_a_set_in <= 8'h00;
    endtask
    task sums(input logic [7:0] exp);
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
        chk({6'h00, rx_cond_a_summary_out, rx_cond_b_summary_out}, exp);
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd(8'h0a, 8'h02);
        rd(8'h09, 8'h20);
        rd(8'h0b, 8'h00);
        rd(8'h55, 8'h00);
        wr(8'h0a, 8'h00);
        rd(8'h0a, 8'h02);
        @(posedge clk_in) state_reload_in <= 1'b1;
        noise_reload_in <= 1'b1;
        @(posedge clk_in) state_reload_in <= 1'b0;
        noise_reload_in <= 1'b0;
        wr(8'h0a, 8'h00);
        wr(8'h09, 8'h00);
        rd(8'h0a, 8'h00);
        rd(8'h09, 8'h00);
        // Counters reach zero again: flags stick through a clear
        @(posedge clk_in) state_cnt_zero_in <= 1'b1;
        noise_cnt_zero_in <= 1'b1;
        @(posedge clk_in) state_cnt_zero_in <= 1'b0;
        noise_cnt_zero_in <= 1'b0;
        wr(8'h0a, 8'h00);
        wr(8'h09, 8'h00);
        rd(8'h0a, 8'h02);
        rd(8'h09, 8'h20);
        @(posedge clk_in) state_reload_in <= 1'b1;
        noise_reload_in <= 1'b1;
        @(posedge clk_in) state_reload_in <= 1'b0;
        noise_reload_in <= 1'b0;
        wr(8'h0a, 8'h00);
        wr(8'h09, 8'h00);
        rd(8'h0a, 8'h00);
        rd(8'h09, 8'h00);
        // Idle pair counts: one, seven, then eight
        pairs(1, 5'h1f, 5'h1f);
        pairs(1, 5'h00, 5'h00);
        rd(8'h0a, 8'h00);
        pairs(7, 5'h1f, 5'h1f);
        pairs(1, 5'h00, 5'h00);
        rd(8'h0a, 8'h01);
        pairs(8, 5'h1f, 5'h1f);
        rd(8'h0a, 8'h41);
        wr(8'h0a, 8'h00);
        pairs(1, 5'h18, 5'h11);
        @(posedge clk_in) unknown_in <= 1'b1;
        @(posedge clk_in) unknown_in <= 1'b0;
        rd(8'h0a, 8'h0c);
        // Management event only when masked in
        @(posedge clk_in) conn_mgmt_cond_in <= 8'h01;
        rd(8'h0a, 8'h0c);
        @(posedge clk_in) conn_mgmt_cond_mask_in <= 8'h01;
        @(posedge clk_in) conn_mgmt_cond_in <= 8'h00;
        conn_mgmt_cond_mask_in <= 8'h00;
        rd(8'h0a, 8'h1c);
        wr(8'h0a, 8'h00);
        // Cascade: no start at all, then prompt start
        wr(8'h40, 8'h01);
        @(posedge clk_in) chain_ready_in <= 1'b1;
        @(posedge clk_in) chain_ready_in <= 1'b0;
        repeat (8) @(posedge clk_in);
        rd(8'h0a, 8'h10);
        wr(8'h0a, 8'h00);
        @(posedge clk_in) chain_ready_in <= 1'b1;
        @(posedge clk_in) chain_ready_in <= 1'b0;
        chain_start_in <= 1'b1;
        repeat (8) @(posedge clk_in);
        chain_start_in <= 1'b0;
        rd(8'h0a, 8'h00);
        wr(8'h40, 8'h00);
        // Slip, summary B, write of ones, set beside clear
        wr(8'h0c, 8'h20);
        @(posedge clk_in) slip_in <= 1'b1;
        @(posedge clk_in) slip_in <= 1'b0;
        sums(8'h01);
        wr(8'h0a, 8'hff);
        rd(8'h0a, 8'h20);
        wr(8'h0a, 8'h00);
        @(posedge clk_in) slip_in <= 1'b1;
        wr_in <= 1'b1;
        addr_in <= 8'h0a;
        wdata_in <= 8'h00;
        @(posedge clk_in) slip_in <= 1'b0;
        wr_in <= 1'b0;
        rd_in <= 1'b1;
        @(posedge clk_in) rd_in <= 1'b0;
        @(negedge clk_in) chk(rdata_out, 8'h20);
        wr(8'h0a, 8'h00);
        sums(8'h00);
        // Each companion flag against its own enable bit
        for (i = 0; i < 8; i++) begin
            wr(8'h0b, ~(8'h01 << i));
            pulse_a(8'h01 << i);
            sums(8'h00);
            wr(8'h0b, 8'h01 << i);
            pulse_a(8'h01 << i);
            sums(8'h02);
            rd(8'h09, 8'h01 << i);
            wr(8'h09, 8'h00);
        end
        conclude;
    end
endmodule // rx_line_state_event_flags_tb_top

bind rx_line_state_event_flags rx_flags_monitor rx_flags_monitor_inst (
    .clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .slip_in, .flags_a_set_in, .rx_cond_a_summary_out,
    .rx_cond_b_summary_out);
